// File: rtl/hps_defines.svh
// Register map, field positions, reset values and timing counts of the power sequencer.
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define HPS_ADDR_CTRL 8'h00
`define HPS_ADDR_FIFO 8'h04
`define HPS_ADDR_STATUS 8'h08
`define HPS_ADDR_SCALE 8'h0C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define HPS_CTRL_STANDBY 0
`define HPS_CTRL_FORCE 1
`define HPS_CTRL_GO 2
`define HPS_CTRL_SRST 3
`define HPS_CTRL_TMO_LO 4
`define HPS_CTRL_SCALE_LO 6
`define HPS_CTRL_MODE_LO 8
`define HPS_CTRL_RESET 10'h001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HPS_CLK_HZ 100000000
`define HPS_SAMPLE_HZ 8000
`define HPS_STARTUP_MS 2
`define HPS_TIMEOUT_STEP_MS 5
`define HPS_STARTUP_TICKS (`HPS_STARTUP_MS * `HPS_SAMPLE_HZ / 1000)
`define HPS_TIMEOUT_STEP_TICKS (`HPS_TIMEOUT_STEP_MS * `HPS_SAMPLE_HZ / 1000)
`define HPS_SCALE_STEP_V 25
`define HPS_DAC_MID 8'h00
`define HPS_FIFO_DEPTH 8
`define HPS_AXI_OKAY 2'b00
`define HPS_AXI_SLVERR 2'b10

`endif

// File: rtl/hps_fifo.sv
// Parameterised valid/ready FIFO for waveform samples.
`timescale 1ns/1ns
module hps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wp_nxt = push ? AW'((wp_r == AW'(DEPTH - 1)) ? 0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'((rp_r == AW'(DEPTH - 1)) ? 0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
    if (rst)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    wp_r <= wp_nxt;
    rp_r <= rp_nxt;
    cnt_r <= cnt_nxt;
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // hps_fifo

// File: rtl/hps_pkg.sv
// Types shared by the power sequencer design.
package hps_pkg;
  typedef enum logic [2:0] {
    HPS_STANDBY,
    HPS_IDLE,
    HPS_STARTUP,
    HPS_PLAY,
    HPS_HOLD,
    HPS_RAMP
  } hps_state_t;

  typedef enum logic [1:0] {
    HPS_MODE_FIFO,
    HPS_MODE_RAM,
    HPS_MODE_SYNTH,
    HPS_MODE_RSVD
  } hps_mode_t;
endpackage

// File: rtl/hps_sequencer.sv
// Playback power sequencer with AXI4-Lite register slave.
`timescale 1ns/1ns
`include "hps_defines.svh"
module hps_sequencer
  import hps_pkg::*;
#(
  parameter int TICK_DIV = `HPS_CLK_HZ / `HPS_SAMPLE_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_play_done,
  output logic mem_play_start,
  output logic boost_en,
  output logic amp_en,
  output logic [7:0] dac_code,
  output logic dac_strobe,
  output logic [6:0] full_scale_volts
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [6:0] scale_volts(input logic [1:0] code);
    scale_volts = 7'(`HPS_SCALE_STEP_V * (int'(code) + 1));
  endfunction

  localparam logic [7:0] STARTUP_TICKS = 8'(`HPS_STARTUP_TICKS);
  localparam logic [7:0] TMO_STEP = 8'(`HPS_TIMEOUT_STEP_TICKS);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  hps_state_t st_r, st_nxt;
  logic [9:0] ctrl_r, ctrl_nxt;
  logic force_prev_r, force_prev_nxt;
  logic srst_r, srst_nxt;
  logic go_pend_r, go_pend_nxt;
  logic mem_act_r, mem_act_nxt;
  logic mem_start_r, mem_start_nxt;
  logic [13:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] tcnt_r, tcnt_nxt;
  logic [7:0] dac_r, dac_nxt;
  logic strobe_r, strobe_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic rst;
  logic standby;
  logic force_on;
  hps_mode_t mode;
  logic [7:0] tmo_ticks;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic wr_go, wr_fifo, fifo_stall;

  assign rst = !aresetn || srst_r;
  assign standby = ctrl_r[`HPS_CTRL_STANDBY];
  assign force_on = ctrl_r[`HPS_CTRL_FORCE];
  assign mode = hps_mode_t'(ctrl_r[`HPS_CTRL_MODE_LO +: 2]);
  assign tmo_ticks = 8'(TMO_STEP * (int'(ctrl_r[`HPS_CTRL_TMO_LO +: 2]) + 1));

  // --------------------------------------------------------------------------
  // Sample FIFO
  // --------------------------------------------------------------------------
  // Writes are dropped in standby and during ramp-down; a full FIFO instead
  // stalls the bus write so no sample is lost.
  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign wr_fifo = wr_go && awaddr_r == `HPS_ADDR_FIFO && wstrb_r[0];
  assign fifo_in_valid = wr_fifo && !standby && st_r != HPS_RAMP;
  assign fifo_stall = fifo_in_valid && !fifo_in_ready;
  assign fifo_pop = st_r == HPS_PLAY && tick_r && fifo_out_valid;

  hps_fifo #(
    .WIDTH(8),
    .DEPTH(`HPS_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .rst(rst || standby),
    .in_data(wdata_r[7:0]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    srst_nxt = 1'b0;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt[`HPS_CTRL_GO] = 1'b0;
    if (s_axi_awvalid && !aw_have_r)
    begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_r)
    begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_go && !fifo_stall)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `HPS_AXI_OKAY;
      case (awaddr_r)
        `HPS_ADDR_CTRL:
        begin
          if (wstrb_r[0])
          begin
            ctrl_nxt[7:0] = wdata_r[7:0];
          end
          if (wstrb_r[1])
          begin
            ctrl_nxt[9:8] = wdata_r[9:8];
          end
          srst_nxt = wstrb_r[0] && wdata_r[`HPS_CTRL_SRST];
          ctrl_nxt[`HPS_CTRL_SRST] = 1'b0;
        end
        `HPS_ADDR_FIFO, `HPS_ADDR_STATUS, `HPS_ADDR_SCALE:
        begin
          bresp_nxt = `HPS_AXI_OKAY;
        end
        default:
        begin
          bresp_nxt = `HPS_AXI_SLVERR;
        end
      endcase
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `HPS_AXI_OKAY;
      case (s_axi_araddr)
        `HPS_ADDR_CTRL: rdata_nxt = {22'h00_0000, ctrl_r};
        `HPS_ADDR_FIFO: rdata_nxt = 32'h0000_0000;
        `HPS_ADDR_STATUS: rdata_nxt = {16'h0000, dac_r, 1'b0, !fifo_in_ready,
          fifo_out_valid, boost_en, mem_act_r, 3'(st_r)};
        `HPS_ADDR_SCALE: rdata_nxt = {25'h000_0000, full_scale_volts};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `HPS_AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (rst)
    begin
      ctrl_nxt = `HPS_CTRL_RESET;
      srst_nxt = 1'b0;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      awaddr_nxt = 8'h00;
      wdata_nxt = 32'h0000_0000;
      wstrb_nxt = 4'h0;
      bresp_nxt = `HPS_AXI_OKAY;
      rvalid_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = `HPS_AXI_OKAY;
      // A soft reset arrives by a bus write whose answer must still go out.
      bvalid_nxt = aresetn && srst_r;
    end
  end

  // --------------------------------------------------------------------------
  // Sample-rate divider and power sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    tcnt_nxt = tcnt_r;
    dac_nxt = dac_r;
    strobe_nxt = 1'b0;
    mem_start_nxt = 1'b0;
    mem_act_nxt = mem_act_r && !mem_play_done;
    force_prev_nxt = force_on;
    go_pend_nxt = go_pend_r;
    div_nxt = (div_r == 14'(TICK_DIV - 1)) ? 14'h0000 : div_r + 1'b1;
    tick_nxt = (div_r == 14'(TICK_DIV - 1));
    if (ctrl_r[`HPS_CTRL_GO] && mode != HPS_MODE_FIFO && !standby)
    begin
      go_pend_nxt = 1'b1;
    end
    case (st_r)
      HPS_STANDBY:
      begin
        go_pend_nxt = 1'b0;
        if (!standby)
        begin
          st_nxt = HPS_IDLE;
        end
      end
      HPS_IDLE:
      begin
        if (fifo_out_valid || go_pend_r || (force_on && !force_prev_r) || force_on)
        begin
          st_nxt = HPS_STARTUP;
          tcnt_nxt = 8'h00;
        end
      end
      HPS_STARTUP:
      begin
        // New requests here only queue; the wake-up timer keeps running.
        if (tick_r)
        begin
          tcnt_nxt = tcnt_r + 1'b1;
        end
        if (tick_r && tcnt_r == STARTUP_TICKS - 1'b1)
        begin
          st_nxt = HPS_PLAY;
        end
      end
      HPS_PLAY:
      begin
        if (go_pend_r && !mem_act_r)
        begin
          go_pend_nxt = 1'b0;
          mem_act_nxt = 1'b1;
          mem_start_nxt = 1'b1;
        end
        if (fifo_pop)
        begin
          dac_nxt = fifo_out_data;
          strobe_nxt = 1'b1;
        end
        else if (!fifo_out_valid && !mem_act_r && !go_pend_r)
        begin
          st_nxt = HPS_HOLD;
          tcnt_nxt = 8'h00;
        end
      end
      HPS_HOLD:
      begin
        if (fifo_out_valid || go_pend_r)
        begin
          st_nxt = HPS_PLAY;
        end
        else if (force_on)
        begin
          tcnt_nxt = 8'h00;
        end
        else if (tick_r)
        begin
          tcnt_nxt = tcnt_r + 1'b1;
          if (tcnt_r == tmo_ticks - 1'b1)
          begin
            st_nxt = (dac_r != `HPS_DAC_MID) ? HPS_RAMP : HPS_IDLE;
          end
        end
      end
      HPS_RAMP:
      begin
        // One LSB per sample keeps the worst-case ramp near 16 ms and pop-free.
        if (dac_r == `HPS_DAC_MID)
        begin
          st_nxt = HPS_IDLE;
        end
        else if (tick_r)
        begin
          dac_nxt = dac_r[7] ? dac_r + 1'b1 : dac_r - 1'b1;
          strobe_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt = HPS_STANDBY;
      end
    endcase
    if (standby)
    begin
      st_nxt = HPS_STANDBY;
      mem_act_nxt = 1'b0;
    end
    if (rst)
    begin
      st_nxt = HPS_STANDBY;
      tcnt_nxt = 8'h00;
      dac_nxt = `HPS_DAC_MID;
      strobe_nxt = 1'b0;
      mem_start_nxt = 1'b0;
      mem_act_nxt = 1'b0;
      force_prev_nxt = 1'b0;
      go_pend_nxt = 1'b0;
      div_nxt = 14'h0000;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
    ctrl_r <= ctrl_nxt;
    force_prev_r <= force_prev_nxt;
    srst_r <= srst_nxt;
    go_pend_r <= go_pend_nxt;
    mem_act_r <= mem_act_nxt;
    mem_start_r <= mem_start_nxt;
    div_r <= div_nxt;
    tick_r <= tick_nxt;
    tcnt_r <= tcnt_nxt;
    dac_r <= dac_nxt;
    strobe_r <= strobe_nxt;
    aw_have_r <= aw_have_nxt;
    w_have_r <= w_have_nxt;
    awaddr_r <= awaddr_nxt;
    wdata_r <= wdata_nxt;
    wstrb_r <= wstrb_nxt;
    bvalid_r <= bvalid_nxt;
    bresp_r <= bresp_nxt;
    rvalid_r <= rvalid_nxt;
    rdata_r <= rdata_nxt;
    rresp_r <= rresp_nxt;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign boost_en = st_r != HPS_STANDBY && st_r != HPS_IDLE;
  assign amp_en = boost_en;
  assign dac_code = dac_r;
  assign dac_strobe = strobe_r;
  assign mem_play_start = mem_start_r;
  assign full_scale_volts = scale_volts(ctrl_r[`HPS_CTRL_SCALE_LO +: 2]);
endmodule // hps_sequencer

// File: tb/hps_host_model.sv
// Host model: AXI4-Lite master tasks and a memory playback engine stub.
`timescale 1ns/1ns
module hps_host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic mem_play_start,
  output logic mem_play_done
);
  int mem_cnt = 0;

  // Ready is held high throughout, so every answer is taken at once.
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, mem_play_done} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (mem_play_start === 1'b1)
      mem_cnt <= 20;
    else if (mem_cnt > 0)
      mem_cnt <= mem_cnt - 1;
    mem_play_done <= (mem_cnt == 1);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 5000);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 5000);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule // hps_host_model

// File: tb/hps_monitor.sv
// Port-level concurrent checks for the playback power sequencer.
`timescale 1ns/1ns
module hps_monitor #(
  parameter int TICK_DIV = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic mem_play_start,
  input wire logic boost_en,
  input wire logic amp_en,
  input wire logic dac_strobe,
  input wire logic [6:0] full_scale_volts
);
  // One tick of slack, since the startup count may begin mid-tick.
  localparam int WAKE_MIN = 15 * TICK_DIV;
  logic [15:0] on_cnt_r;
  logic [15:0] on_cnt_nxt;

  always_comb
  begin
    on_cnt_nxt = on_cnt_r;
    if (!boost_en)
      on_cnt_nxt = 16'h0000;
    else if (on_cnt_r != 16'hFFFF)
      on_cnt_nxt = on_cnt_r + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      on_cnt_r <= 16'h0000;
    else
      on_cnt_r <= on_cnt_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_enables_paired: assert property (boost_en == amp_en)
    else $error("boost and amplifier enables differ");
  a_strobe_after_wake: assert property (dac_strobe |-> on_cnt_r >= WAKE_MIN)
    else $error("sample sent before wake-up finished");
  a_start_after_wake: assert property (mem_play_start |-> on_cnt_r >= WAKE_MIN)
    else $error("memory playback started before wake-up finished");
  a_strobe_spacing: assert property (dac_strobe |=> !dac_strobe [*8])
    else $error("samples closer than one sample period");
  a_start_pulse: assert property (mem_play_start |=> !mem_play_start)
    else $error("playback start repeated");
  a_scale_legal: assert property (full_scale_volts inside {7'd25, 7'd50, 7'd75, 7'd100})
    else $error("illegal full scale value");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:300] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");

  cover property (dac_strobe);
  cover property (mem_play_start);
  cover property ($fell(boost_en));
endmodule // hps_monitor

// File: tb/hps_sequencer_tb_top.sv
// Self-checking testbench for the playback power sequencer.
`timescale 1ns/1ns
module hps_sequencer_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dac_code;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_play_done, mem_play_start, boost_en, amp_en, dac_strobe;
  logic [6:0] full_scale_volts;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] smp[$];
  int tms[$];

  hps_sequencer #(.TICK_DIV(10)) i_hps_sequencer (.*);
  hps_host_model i_hps_host_model (.*);

  always #5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (dac_strobe === 1'b1)
    begin
      smp.push_back(dac_code);
      tms.push_back(cyc);
    end
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_hps_host_model.wr(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    i_hps_host_model.rd(a, d, r);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d);
    chk(d, 32'h0000_0001);
    chk(32'(boost_en), 32'h0000_0000);
    i_hps_host_model.rd(8'h10, d, r);
    chk(32'(r), 32'h0000_0002);
    i_hps_host_model.wr(8'h14, 32'h0000_0000, r);
    chk(32'(r), 32'h0000_0002);
  endtask

  task automatic t_scale;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, 32'(c) << 6);
      chk(32'(full_scale_volts), 32'(25 * (c + 1)));
    end
    wr(8'h00, 32'h0000_0000);
  endtask

  // Eight bytes fill the buffer; the last one is left off mid-scale so the ramp runs.
  task automatic t_fifo;
    logic [31:0] d;
    int n;
    chk(32'(boost_en), 32'h0000_0000);
    for (int i = 0; i < 8; i++)
      wr(8'h04, 32'(i + 1));
    rd(8'h08, d);
    chk(32'(d[6]), 32'h0000_0001);
    chk(32'(boost_en), 32'h0000_0001);
    for (n = 0; n < 3000 && smp.size() < 9; n++)
      @(posedge aclk);
    wr(8'h04, 32'h0000_0055);
    for (n = 0; n < 3000 && boost_en !== 1'b0; n++)
      @(posedge aclk);
    chk(32'(smp.size()), 32'd16);
    for (int i = 0; i < 16 && i < smp.size(); i++)
      chk(32'(smp[i]), (i < 8) ? 32'(i + 1) : 32'(15 - i));
    chk(32'(tms[8] - tms[7] >= 390 && tms[8] - tms[7] <= 420), 32'd1);
    chk(32'(dac_code), 32'h0000_0000);
  endtask

  task automatic t_force;
    logic [31:0] d;
    int k;
    wr(8'h00, 32'h0000_0002);
    repeat (5) @(posedge aclk);
    chk(32'(boost_en), 32'h0000_0001);
    repeat (700) @(posedge aclk);
    chk(32'(boost_en), 32'h0000_0001);
    k = smp.size();
    wr(8'h04, 32'h0000_0011);
    repeat (25) @(posedge aclk);
    chk(32'(smp.size()), 32'(k + 1));
    wr(8'h00, 32'h0000_0003);
    wr(8'h04, 32'h0000_0022);
    rd(8'h08, d);
    chk(32'(boost_en), 32'h0000_0000);
    chk({d[5], d[2:0]}, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    rd(8'h08, d);
    chk(32'(d[2:0]), 32'h0000_0001);
  endtask

  task automatic t_ram;
    int t0;
    int n;
    wr(8'h00, 32'h0000_0104);
    t0 = cyc;
    repeat (80) @(posedge aclk);
    wr(8'h00, 32'h0000_0104);
    for (n = 0; n < 400 && mem_play_start !== 1'b1; n++)
      @(posedge aclk);
    chk(32'(cyc - t0 >= 150 && cyc - t0 <= 200), 32'd1);
  endtask

  task automatic t_srst;
    logic [31:0] d;
    wr(8'h00, 32'h0000_00C2);
    wr(8'h00, 32'h0000_0008);
    rd(8'h00, d);
    chk(d, 32'h0000_0001);
    chk(32'(full_scale_volts), 32'd25);
    chk(32'(boost_en), 32'h0000_0000);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test;
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_scale;
    t_fifo;
    t_force;
    t_ram;
    t_srst;
    end_of_test;
  end
endmodule // hps_sequencer_tb_top

bind hps_sequencer hps_monitor #(.TICK_DIV(TICK_DIV)) i_hps_monitor (.*);
